// [core/hdlc_fifo_route.sv]
// Purpose: Host FIFO ports, packet status and receive HDLC routing
// Assumes: Host port and framer stream are synchronous to core_clk
// Notes:   Host reads answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Receive abort, CRC, overflow, good-message flags latch and clear on status read.
// - Transmit status bit 2 shows live transmit FIFO empty.
// - Transmit status bit 1 shows live transmit FIFO full.
// - Transmit FIFO running dry mid-message sends abort and sets bit 0.
// - Underrun flag holds until a transmit status read clears it.
// - Transmit status bits 7 to 3 are unassigned; they read zero here.
// - Sa routing: select bits 4 down to 0 enable Sa4 through Sa8.
// - Engine push into a full receive FIFO sets the overflow flag.
// - Receive status shows live receive FIFO empty.
module hdlc_fifo_route
  import hdlc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  input wire logic eng_rx_push,
  input wire logic [7:0] eng_rx_data,
  input wire logic eng_rx_abort,
  input wire logic eng_rx_crc_err,
  input wire logic eng_rx_msg_ok,
  input wire logic eng_tx_pop,
  input wire logic eng_tx_in_msg,
  output logic [7:0] eng_tx_data,
  output logic eng_tx_data_valid,
  output logic eng_tx_abort,
  input wire logic ts_strobe,
  input wire logic ts_bit,
  input wire logic [4:0] ts_slot,
  input wire logic [2:0] ts_bit_idx,
  input wire logic ts_nfas,
  input wire logic [31:0] rx_channel_block_regs,
  output logic hdlc_rx_bit,
  output logic hdlc_rx_bit_valid
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] rdata;
    logic rx_abort_seen_flag;
    logic rx_checksum_error_flag;
    logic rx_fifo_overflow_flag;
    logic rx_good_message_flag;
    logic tx_starved_flag;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_abort;
    logic [7:0] route;
    logic [7:0] suppress;
    logic hbit;
    logic hvalid;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;
  fifo_if rxf ();
  fifo_if txf ();

  logic rd_rx_data;
  logic rd_rx_stat;
  logic rd_tx_stat;
  logic wr_tx_data;
  logic tx_underrun;
  logic chan_hit;
  logic take_bit;

  byte_fifo u_rx_fifo (.core_clk(core_clk), .nrst(nrst), .f(rxf));
  byte_fifo u_tx_fifo (.core_clk(core_clk), .nrst(nrst), .f(txf));

  // ****************************************************************
  // Decode and FIFO hookup
  // ****************************************************************
  assign rd_rx_data = host_rd && (host_addr == RX_PACKET_FIFO_DATA_ADDR);
  assign rd_rx_stat = host_rd && (host_addr == RX_PACKET_STATUS_ADDR);
  assign rd_tx_stat = host_rd && (host_addr == TX_PACKET_STATUS_ADDR);
  assign wr_tx_data = host_wr && (host_addr == TX_PACKET_FIFO_DATA_ADDR);
  // Engine push into a full FIFO is dropped; it only raises the flag
  assign rxf.push = eng_rx_push && !rxf.full;
  assign rxf.push_data = eng_rx_data;
  assign rxf.pop = rd_rx_data && !rxf.empty;
  // A write into a full transmit FIFO is lost; host polls the full bit
  assign txf.push = wr_tx_data && !txf.full;
  assign txf.push_data = host_wdata;
  assign txf.pop = eng_tx_pop && !txf.empty;
  assign tx_underrun = eng_tx_pop && txf.empty && eng_tx_in_msg;

  // ****************************************************************
  // Receive routing
  // ****************************************************************
  always_comb
  begin
    if (s_q.route[RT_BLOCK_BIT])
    begin
      chan_hit = rx_channel_block_regs[ts_slot];
    end
    else
    begin
      chan_hit = (ts_slot == s_q.route[4:0]);
    end
    take_bit = 1'b0;
    if (ts_strobe && s_q.route[RT_ENABLE_BIT])
    begin
      if (s_q.route[RT_DS0_BIT])
      begin
        take_bit = chan_hit && !s_q.suppress[ts_bit_idx];
      end
      else
      begin
        // Sa bits sit in timeslot 0 of frames without the alignment word
        take_bit = (ts_slot == 5'h00) && ts_nfas && (ts_bit_idx >= SA4_BIT_IDX)
                   && s_q.route[SA_MASK_TOP - ts_bit_idx];
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.tx_valid = txf.pop;
    s_d.tx_abort = tx_underrun;
    s_d.hvalid = take_bit;
    if (take_bit)
    begin
      s_d.hbit = ts_bit;
    end
    if (txf.pop)
    begin
      s_d.tx_data = txf.head;
    end
    s_d.rdata = READ_IDLE;
    if (rd_rx_data && !rxf.empty)
    begin
      s_d.rdata = rxf.head;
    end
    if (rd_rx_stat)
    begin
      s_d.rdata[RX_ABORT_BIT] = s_q.rx_abort_seen_flag;
      s_d.rdata[RX_CRC_BIT] = s_q.rx_checksum_error_flag;
      s_d.rdata[RX_OVR_BIT] = s_q.rx_fifo_overflow_flag;
      s_d.rdata[RX_GOOD_BIT] = s_q.rx_good_message_flag;
      s_d.rdata[RX_VACANT_BIT] = rxf.empty;
      s_d.rx_abort_seen_flag = 1'b0;
      s_d.rx_checksum_error_flag = 1'b0;
      s_d.rx_fifo_overflow_flag = 1'b0;
      s_d.rx_good_message_flag = 1'b0;
    end
    if (rd_tx_stat)
    begin
      s_d.rdata[TX_VACANT_BIT] = txf.empty;
      s_d.rdata[TX_SATURATED_BIT] = txf.full;
      s_d.rdata[TX_STARVED_BIT] = s_q.tx_starved_flag;
      s_d.tx_starved_flag = 1'b0;
    end
    if (host_rd && (host_addr == RX_ROUTING_CONTROL_ADDR))
    begin
      s_d.rdata = s_q.route;
    end
    if (host_rd && (host_addr == RX_BIT_SUPPRESS_CONTROL_ADDR))
    begin
      s_d.rdata = s_q.suppress;
    end
    if (host_wr && (host_addr == RX_ROUTING_CONTROL_ADDR))
    begin
      s_d.route = host_wdata;
    end
    if (host_wr && (host_addr == RX_BIT_SUPPRESS_CONTROL_ADDR))
    begin
      s_d.suppress = host_wdata;
    end
    // Sets come last so an event in the clearing read is kept
    if (eng_rx_abort)
    begin
      s_d.rx_abort_seen_flag = 1'b1;
    end
    if (eng_rx_crc_err)
    begin
      s_d.rx_checksum_error_flag = 1'b1;
    end
    if (eng_rx_msg_ok)
    begin
      s_d.rx_good_message_flag = 1'b1;
    end
    if (eng_rx_push && rxf.full)
    begin
      s_d.rx_fifo_overflow_flag = 1'b1;
    end
    if (tx_underrun)
    begin
      s_d.tx_starved_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s_q <= '{rdata: READ_IDLE, tx_data: '0, route: ROUTE_RESET,
               suppress: SUPPRESS_RESET, default: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign host_rdata = s_q.rdata;
  assign eng_tx_data = s_q.tx_data;
  assign eng_tx_data_valid = s_q.tx_valid;
  assign eng_tx_abort = s_q.tx_abort;
  assign hdlc_rx_bit = s_q.hbit;
  assign hdlc_rx_bit_valid = s_q.hvalid;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_rx_flags_clear;
    rd_rx_stat && !eng_rx_abort && !eng_rx_crc_err && !eng_rx_msg_ok && !eng_rx_push
      |=> !s_q.rx_abort_seen_flag && !s_q.rx_checksum_error_flag
          && !s_q.rx_good_message_flag && !s_q.rx_fifo_overflow_flag;
  endproperty
  a_rx_flags_clear: assert property (p_rx_flags_clear)
    else $error("receive flags not cleared by status read");

  property p_tx_vacant_bit;
    rd_tx_stat |=> host_rdata[TX_VACANT_BIT] == $past(u_tx_fifo.s_q.count == 7'h00);
  endproperty
  a_tx_vacant_bit: assert property (p_tx_vacant_bit)
    else $error("transmit empty bit wrong");

  property p_tx_full_bit;
    rd_tx_stat |=> host_rdata[TX_SATURATED_BIT] == $past(u_tx_fifo.s_q.count == FIFO_DEPTH);
  endproperty
  a_tx_full_bit: assert property (p_tx_full_bit)
    else $error("transmit full bit wrong");

  property p_underrun;
    eng_tx_pop && txf.empty && eng_tx_in_msg |=> eng_tx_abort && s_q.tx_starved_flag
      ##1 (!eng_tx_abort || $past(tx_underrun));
  endproperty
  a_underrun: assert property (p_underrun)
    else $error("underrun did not abort and flag");

  property p_starved_hold;
    s_q.tx_starved_flag && !rd_tx_stat |=> s_q.tx_starved_flag;
  endproperty
  a_starved_hold: assert property (p_starved_hold)
    else $error("underrun flag dropped without read");

  property p_reserved_zero;
    rd_tx_stat |=> host_rdata[7:3] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unassigned transmit status bits not zero");

  property p_sa_pick;
    ts_strobe && s_q.route[7:6] == 2'b10 && ts_slot == 5'h00 && ts_nfas
      && ts_bit_idx == 3'h3 |-> ##1 hdlc_rx_bit_valid == $past(s_q.route[4]);
  endproperty
  a_sa_pick: assert property (p_sa_pick)
    else $error("Sa4 select not honoured");

  property p_overflow;
    eng_rx_push && rxf.full |=> s_q.rx_fifo_overflow_flag;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow flag not set");

  property p_suppress;
    ts_strobe && s_q.route[RT_DS0_BIT] && s_q.suppress[ts_bit_idx] |=> !hdlc_rx_bit_valid;
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("suppressed bit was taken");

  property p_rx_vacant;
    rd_rx_stat |=> host_rdata[RX_VACANT_BIT] == $past(rxf.empty);
  endproperty
  a_rx_vacant: assert property (p_rx_vacant)
    else $error("receive empty bit wrong");
endmodule : hdlc_fifo_route
`default_nettype wire

// [include/hdlc_pkg.sv]
// Purpose: Shared constants for the HDLC FIFO and receive routing block
// Assumes: 8-bit host port, one 20 MHz core clock
// Notes:   Offsets are the host byte addresses of the registers
package hdlc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] RX_PACKET_FIFO_DATA_ADDR = 8'hB4;
  localparam logic [7:0] RX_PACKET_STATUS_ADDR = 8'hB5;
  localparam logic [7:0] TX_PACKET_STATUS_ADDR = 8'hB6;
  localparam logic [7:0] TX_PACKET_FIFO_DATA_ADDR = 8'hB7;
  localparam logic [7:0] RX_ROUTING_CONTROL_ADDR = 8'hB8;
  localparam logic [7:0] RX_BIT_SUPPRESS_CONTROL_ADDR = 8'hB9;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RX_ABORT_BIT = 7;
  localparam int RX_CRC_BIT = 6;
  localparam int RX_OVR_BIT = 5;
  localparam int RX_GOOD_BIT = 4;
  localparam int RX_VACANT_BIT = 3;
  localparam int TX_VACANT_BIT = 2;
  localparam int TX_SATURATED_BIT = 1;
  localparam int TX_STARVED_BIT = 0;
  localparam int RT_ENABLE_BIT = 7;
  localparam int RT_DS0_BIT = 6;
  localparam int RT_BLOCK_BIT = 5;
  localparam logic [2:0] SA4_BIT_IDX = 3'h3;
  localparam logic [2:0] SA_MASK_TOP = 3'h7;
  // ****************************************************************
  // Reset values and sizes
  // ****************************************************************
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [7:0] SUPPRESS_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_AW = 6;
  localparam logic [FIFO_AW:0] FIFO_DEPTH = 7'h40;
endpackage : hdlc_pkg

// [include/fifo_if.sv]
// Purpose: Push/pop link between the block core and a byte FIFO
// Assumes: Both ends on core_clk
// Notes:   head always shows the oldest byte one cycle after any change
`timescale 1ns/1ps
`default_nettype none
interface fifo_if;
  logic push;
  logic [7:0] push_data;
  logic pop;
  logic [7:0] head;
  logic empty;
  logic full;
  modport owner (output push, output push_data, output pop,
                 input head, input empty, input full);
  modport store (input push, input push_data, input pop,
                 output head, output empty, output full);
endinterface : fifo_if
`default_nettype wire

// [core/byte_fifo.sv]
// Purpose: 64-byte packet FIFO with registered head and flags
// Assumes: Owner never pushes when full nor pops when empty
// Notes:   Head bypasses a write into an empty FIFO
`timescale 1ns/1ps
`default_nettype none
module byte_fifo
  import hdlc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  fifo_if.store f
);
  typedef struct packed {
    logic [FIFO_AW-1:0] wr_ptr;
    logic [FIFO_AW-1:0] rd_ptr;
    logic [FIFO_AW:0] count;
    logic [7:0] head;
    logic empty;
    logic full;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic [7:0] mem [0:(1<<FIFO_AW)-1];

  always_comb
  begin
    s_d = s_q;
    if (f.push)
    begin
      s_d.wr_ptr = s_q.wr_ptr + 1'b1;
    end
    if (f.pop)
    begin
      s_d.rd_ptr = s_q.rd_ptr + 1'b1;
    end
    s_d.count = s_q.count + {6'h00, f.push} - {6'h00, f.pop};
    s_d.empty = (s_d.count == 7'h00);
    s_d.full = (s_d.count == FIFO_DEPTH);
    // Bypass keeps the head valid when the only byte was just written
    if (f.push && (s_q.wr_ptr == s_d.rd_ptr))
    begin
      s_d.head = f.push_data;
    end
    else
    begin
      s_d.head = mem[s_d.rd_ptr];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s_q <= '{wr_ptr: '0, rd_ptr: '0, count: '0, head: '0, empty: 1'b1, full: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (f.push)
    begin
      mem[s_q.wr_ptr] <= f.push_data;
    end
  end

  assign f.head = s_q.head;
  assign f.empty = s_q.empty;
  assign f.full = s_q.full;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_fifo_first_byte;
    f.push && s_q.empty && !f.pop |=> (f.head == $past(f.push_data)) && !f.empty;
  endproperty
  a_fifo_first_byte: assert property (p_fifo_first_byte)
    else $error("first byte pushed is not at head");
endmodule : byte_fifo
`default_nettype wire

// [testbench/far_end_model.sv]
// Purpose: Far side model: framer timeslot stream and HDLC engine pops
// Assumes: Every request launched just after a core_clk rising edge
// Notes:   Released bit, slot and bit-index lines show inverted data, so a stale bit never passes
`timescale 1ns/1ps
`default_nettype none
module far_end_model
(
  input wire logic core_clk,
  output logic ts_strobe,
  output logic ts_bit,
  output logic [4:0] ts_slot,
  output logic [2:0] ts_bit_idx,
  output logic ts_nfas,
  output logic eng_tx_pop,
  output logic eng_tx_in_msg
);
  // ****
  // Idle levels
  // ****
  initial
  begin
    ts_strobe = 1'b0;
    ts_bit = 1'b0;
    ts_slot = 5'h00;
    ts_bit_idx = 3'h0;
    ts_nfas = 1'b0;
    eng_tx_pop = 1'b0;
    eng_tx_in_msg = 1'b0;
  end
  // ****
  // Requests
  // ****
  task automatic send_bit(input logic [4:0] s, input logic [2:0] i,
                          input logic n, input logic b);
    @(posedge core_clk);
    ts_strobe <= 1'b1;
    ts_slot <= s;
    ts_bit_idx <= i;
    ts_nfas <= n;
    ts_bit <= b;
    @(posedge core_clk);
    ts_strobe <= 1'b0;
    ts_bit <= ~b;
    ts_slot <= ~s;
    ts_bit_idx <= ~i;
  endtask : send_bit
  // Gap lets the engine answer promptly or slowly
  task automatic pop_byte(input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    eng_tx_pop <= 1'b1;
    @(posedge core_clk);
    eng_tx_pop <= 1'b0;
  endtask : pop_byte
  task automatic in_msg(input logic v);
    @(posedge core_clk);
    eng_tx_in_msg <= v;
  endtask : in_msg
endmodule : far_end_model
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for hdlc_fifo_route
// Assumes: far_end_model plays framer and tx engine; rx engine driven here
// Notes:   Host reads answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hdlc_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] host_addr = 8'h00;
  logic host_rd = 1'b0;
  logic host_wr = 1'b0;
  logic [7:0] host_wdata = 8'h00;
  logic eng_rx_push = 1'b0;
  logic [7:0] eng_rx_data = 8'h00;
  logic eng_rx_abort = 1'b0;
  logic eng_rx_crc_err = 1'b0;
  logic eng_rx_msg_ok = 1'b0;
  logic [31:0] rx_channel_block_regs = 32'h0000_0000;
  logic [7:0] host_rdata, eng_tx_data;
  logic eng_tx_data_valid, eng_tx_abort, hdlc_rx_bit, hdlc_rx_bit_valid;
  logic ts_strobe, ts_bit, ts_nfas, eng_tx_pop, eng_tx_in_msg;
  logic [4:0] ts_slot;
  logic [2:0] ts_bit_idx;
  int bad_count = 0;
  int samples_checked = 0;
  always #25 core_clk = ~core_clk;
  hdlc_fifo_route i_hdlc_fifo_route (.core_clk, .nrst, .host_addr, .host_rd, .host_wr,
    .host_wdata, .host_rdata, .eng_rx_push, .eng_rx_data, .eng_rx_abort, .eng_rx_crc_err,
    .eng_rx_msg_ok, .eng_tx_pop, .eng_tx_in_msg, .eng_tx_data, .eng_tx_data_valid,
    .eng_tx_abort, .ts_strobe, .ts_bit, .ts_slot, .ts_bit_idx, .ts_nfas,
    .rx_channel_block_regs, .hdlc_rx_bit, .hdlc_rx_bit_valid);
  far_end_model i_far_end_model (.core_clk, .ts_strobe, .ts_bit, .ts_slot, .ts_bit_idx,
    .ts_nfas, .eng_tx_pop, .eng_tx_in_msg);
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd <= 1'b0;
    #1;
    check(host_rdata, exp);
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_wr <= 1'b0;
  endtask : wr
  // Pulses {push, abort, crc, ok} together for one cycle
  task automatic eng(input logic [3:0] w, input logic [7:0] d);
    @(posedge core_clk);
    {eng_rx_push, eng_rx_abort, eng_rx_crc_err, eng_rx_msg_ok} <= w;
    eng_rx_data <= d;
    @(posedge core_clk);
    {eng_rx_push, eng_rx_abort, eng_rx_crc_err, eng_rx_msg_ok} <= 4'h0;
  endtask : eng
  // Routed bit is registered on the strobe's edge; look once it has settled
  task automatic chk_bit(input logic v, input logic b);
    #1;
    check({6'h00, hdlc_rx_bit_valid, hdlc_rx_bit & hdlc_rx_bit_valid}, {6'h00, v, v & b});
  endtask : chk_bit
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rd_chk(RX_ROUTING_CONTROL_ADDR, 8'h00);
    rd_chk(RX_BIT_SUPPRESS_CONTROL_ADDR, 8'h00);
    wr(RX_BIT_SUPPRESS_CONTROL_ADDR, 8'h5A);
    rd_chk(RX_BIT_SUPPRESS_CONTROL_ADDR, 8'h5A);
    wr(8'hC3, 8'hFF);
    rd_chk(8'hC3, 8'h00);
  endtask : t_regs
  task automatic t_tx_fifo;
    rd_chk(TX_PACKET_STATUS_ADDR, 8'h04);
    for (int i = 0; i < int'(FIFO_DEPTH); i++)
      wr(TX_PACKET_FIFO_DATA_ADDR, 8'(i) ^ 8'h5A);
    rd_chk(TX_PACKET_STATUS_ADDR, 8'h02);
    wr(TX_PACKET_FIFO_DATA_ADDR, 8'hEE);
    for (int i = 0; i < int'(FIFO_DEPTH); i++)
    begin
      i_far_end_model.pop_byte(i % 3);
      #1;
      check({eng_tx_data_valid, eng_tx_abort, 6'h00}, 8'h80);
      check(eng_tx_data, 8'(i) ^ 8'h5A);
    end
    rd_chk(TX_PACKET_STATUS_ADDR, 8'h04);
  endtask : t_tx_fifo
  task automatic t_underrun;
    i_far_end_model.pop_byte(0);
    #1;
    check({eng_tx_data_valid, eng_tx_abort, 6'h00}, 8'h00);
    rd_chk(TX_PACKET_STATUS_ADDR, 8'h04);
    i_far_end_model.in_msg(1'b1);
    i_far_end_model.pop_byte(0);
    #1;
    check({eng_tx_data_valid, eng_tx_abort, 6'h00}, 8'h40);
    i_far_end_model.in_msg(1'b0);
    repeat (3) @(posedge core_clk);
    rd_chk(TX_PACKET_STATUS_ADDR, 8'h05);
    rd_chk(TX_PACKET_STATUS_ADDR, 8'h04);
  endtask : t_underrun
  task automatic t_rx;
    rd_chk(RX_PACKET_STATUS_ADDR, 8'h08);
    eng(4'h8, 8'hA5);
    eng(4'h8, 8'h3C);
    rd_chk(RX_PACKET_STATUS_ADDR, 8'h00);
    rd_chk(RX_PACKET_FIFO_DATA_ADDR, 8'hA5);
    rd_chk(RX_PACKET_FIFO_DATA_ADDR, 8'h3C);
    rd_chk(RX_PACKET_STATUS_ADDR, 8'h08);
    rd_chk(RX_PACKET_FIFO_DATA_ADDR, 8'h00);
    eng(4'h7, 8'h00);
    rd_chk(RX_PACKET_STATUS_ADDR, 8'hD8);
    rd_chk(RX_PACKET_STATUS_ADDR, 8'h08);
    for (int i = 0; i < int'(FIFO_DEPTH); i++)
      eng(4'h8, 8'(i) + 8'h11);
    eng(4'h8, 8'hFF);
    rd_chk(RX_PACKET_STATUS_ADDR, 8'h20);
    rd_chk(RX_PACKET_STATUS_ADDR, 8'h00);
    for (int i = 0; i < int'(FIFO_DEPTH); i++)
      rd_chk(RX_PACKET_FIFO_DATA_ADDR, 8'(i) + 8'h11);
    rd_chk(RX_PACKET_STATUS_ADDR, 8'h08);
  endtask : t_rx
  task automatic t_sa_route;
    logic [4:0] m;
    for (int k = 0; k < 2; k++)
    begin
      m = (k == 0) ? 5'h15 : 5'h0A;
      wr(RX_ROUTING_CONTROL_ADDR, {3'h4, m});
      rd_chk(RX_ROUTING_CONTROL_ADDR, {3'h4, m});
      for (int i = 3; i < 8; i++)
      begin
        i_far_end_model.send_bit(5'h00, 3'(i), 1'b1, i[0]);
        chk_bit(m[7 - i], i[0]);
      end
      i_far_end_model.send_bit(5'h00, 3'h3, 1'b0, 1'b1);
      chk_bit(1'b0, 1'b0);
    end
  endtask : t_sa_route
  task automatic t_ds0_route;
    wr(RX_ROUTING_CONTROL_ADDR, 8'hC9);
    wr(RX_BIT_SUPPRESS_CONTROL_ADDR, 8'h81);
    for (int i = 0; i < 8; i++)
    begin
      i_far_end_model.send_bit(5'h09, 3'(i), 1'b0, ~i[0]);
      chk_bit(!(i == 0 || i == 7), ~i[0]);
    end
    i_far_end_model.send_bit(5'h0A, 3'h4, 1'b0, 1'b1);
    chk_bit(1'b0, 1'b0);
    @(posedge core_clk);
    rx_channel_block_regs <= 32'h0000_0402;
    wr(RX_ROUTING_CONTROL_ADDR, 8'hE0);
    wr(RX_BIT_SUPPRESS_CONTROL_ADDR, 8'h00);
    i_far_end_model.send_bit(5'h0A, 3'h4, 1'b0, 1'b1);
    chk_bit(1'b1, 1'b1);
    i_far_end_model.send_bit(5'h01, 3'h0, 1'b0, 1'b0);
    chk_bit(1'b1, 1'b0);
    i_far_end_model.send_bit(5'h09, 3'h4, 1'b0, 1'b1);
    chk_bit(1'b0, 1'b0);
    wr(RX_ROUTING_CONTROL_ADDR, 8'h60);
    i_far_end_model.send_bit(5'h0A, 3'h4, 1'b0, 1'b1);
    chk_bit(1'b0, 1'b0);
  endtask : t_ds0_route
  // ****
  // Main sequence and watchdog
  // ****
  initial
  begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_tx_fifo();
    t_underrun();
    t_rx();
    t_sa_route();
    t_ds0_route();
    final_report();
  end
  // Whole run needs under 2000 cycles; allow ten times that
  initial
  begin
    #1_000_000;
    bad_count++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
